// *** verilog/pllbw_pkg.sv ***
// register map, field positions and reset values of the pll control block
`default_nettype none
package pllbw_pkg;
  localparam logic [11:0] PLLBW_CTL_OFF = 12'h000;
  localparam logic [11:0] PLLBW_BWC_OFF = 12'h004;
  localparam logic [11:0] PLLBW_PRG_OFF = 12'h008;
  localparam int PLLBW_IE_BIT = 7;
  localparam int PLLBW_FLAG_BIT = 6;
  localparam int PLLBW_ON_BIT = 5;
  localparam int PLLBW_BCS_BIT = 4;
  localparam int PLLBW_AUTO_BIT = 7;
  localparam int PLLBW_LOCK_BIT = 6;
  localparam int PLLBW_ACQ_BIT = 5;
  localparam int PLLBW_XLD_BIT = 4;
  localparam logic [3:0] PLLBW_CTL_LOW = 4'hf;
  localparam logic [3:0] PLLBW_MUL_RST = 4'h6;
  localparam logic [3:0] PLLBW_VRS_RST = 4'h6;
endpackage
`default_nettype wire

// *** verilog/pllbw_ctl.sv ***
// pll bandwidth, programming and control registers behind an apb slave
//
// Functional notes
// R1: auto bit read/write, reset to manual
// R2: software clears acq before enabling pll manually
// R3: lock reads live state only in auto
// R4: acq indicator in auto, forces mode manually
// R5: shadow of manual acq kept during auto
// R6: software writes xld, waits 4N, reads
// R7: xld shows crystal loss only when bcs set
// R8: software writes zeros to reserved low bits
// R9: multiplier code zero acts as one
// R10: multiplier resets to six
// R11: multiplier writes ignored while pll on
// R12: vco range field, reset to six
// R13: vco range writes blocked while pll on
// R14: range zero disables pll, clears bcs
// R15: lock change in auto sets flag
// R16: manual mode suppresses flag and interrupt
// R17: software checks lock before selecting vco
// R18: vco select allowed without lock
// R19: wait mode changes nothing
// R20: stop holds outputs low
// R21: stop clears bcs, stays clear
// R22: break protects flag unless clear enabled
// R23: control register read clears flag
// R24: bcs chooses vco or crystal half clock
// R25: lock and crystal loss inputs synchronised
`timescale 1ns/1ps
`default_nettype none
module pllbw_ctl
  import pllbw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscillator_enable,
  input wire logic break_active,
  input wire logic break_clear_enable,
  input wire logic wait_mode,
  input wire logic lock_in,
  input wire logic tracking_in,
  input wire logic crystal_loss_in,
  input wire logic vco_half,
  input wire logic crystal_half,
  output logic base_clock_output,
  output logic clockgen_interrupt,
  output logic pll_enable,
  output logic [3:0] multiplier_n,
  output logic [3:0] vco_range,
  output logic force_tracking,
  output logic auto_mode
);
  import pllbw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic pll_interrupt_enable_reg;
  logic pll_interrupt_flag_reg;
  logic pll_on_control_reg;
  logic base_clock_select_reg;
  logic auto_reg;
  logic acq_shadow_reg;
  logic crystal_loss_reg;
  logic [3:0] multiplier_field_reg;
  logic [3:0] vco_range_field_reg;
  logic lock_s1_reg, lock_s2_reg, lock_prev_reg;
  logic trk_s1_reg, trk_s2_reg;
  logic xl_s1_reg, xl_s2_reg;
  logic access, wr, rd, sel_ctl, sel_bwc, sel_prg, mapped;
  logic flag_clear, lock_change;
  logic stop;

  assign stop = !oscillator_enable;
  assign access = psel && penable;
  assign sel_ctl = paddr == PLLBW_CTL_OFF;
  assign sel_bwc = paddr == PLLBW_BWC_OFF;
  assign sel_prg = paddr == PLLBW_PRG_OFF;
  assign mapped = sel_ctl || sel_bwc || sel_prg;
  assign wr = access && pwrite && mapped;
  assign rd = access && !pwrite;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // R25: two-flop synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
      trk_s1_reg <= 1'b0;
      trk_s2_reg <= 1'b0;
      xl_s1_reg <= 1'b0;
      xl_s2_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
    end else begin
      lock_s1_reg <= lock_in;
      lock_s2_reg <= lock_s1_reg;
      trk_s1_reg <= tracking_in;
      trk_s2_reg <= trk_s1_reg;
      xl_s1_reg <= crystal_loss_in;
      xl_s2_reg <= xl_s1_reg;
      lock_prev_reg <= lock_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R19: wait_mode deliberately unused by all state below
  logic lock_vis;
  // R3: lock visible only in auto
  assign lock_vis = auto_reg && lock_s2_reg;
  // R15: toggle of lock in auto
  assign lock_change = auto_reg && (lock_s2_reg != lock_prev_reg);
  // R23: control read clears flag; R22: break guard
  assign flag_clear = rd && sel_ctl && (!break_active || break_clear_enable);

  // R15: set wins over clear; R16: manual keeps flag clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_interrupt_flag_reg <= 1'b0;
    end else if (!auto_reg) begin
      pll_interrupt_flag_reg <= 1'b0;
    end else if (lock_change) begin
      pll_interrupt_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      pll_interrupt_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_interrupt_enable_reg <= 1'b0;
    end else if (!auto_reg) begin
      pll_interrupt_enable_reg <= 1'b0;
    end else if (wr && sel_ctl) begin
      pll_interrupt_enable_reg <= pwdata[PLLBW_IE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll on and base clock select with mutual protection
  logic on_next, bcs_next;
  always_comb begin
    on_next = pll_on_control_reg;
    bcs_next = base_clock_select_reg;
    if (wr && sel_ctl) begin
      on_next = pwdata[PLLBW_ON_BIT] || base_clock_select_reg;
      // R18: no lock check gates the select
      bcs_next = pwdata[PLLBW_BCS_BIT] && pll_on_control_reg;
    end
    // R14: zero range disables pll and select
    if (vco_range_field_reg == 4'h0) begin
      bcs_next = 1'b0;
    end
    // R21: stop clears select
    if (stop) begin
      bcs_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_on_control_reg <= 1'b1;
      base_clock_select_reg <= 1'b0;
    end else begin
      pll_on_control_reg <= on_next;
      base_clock_select_reg <= bcs_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R1: auto bit; R5: shadow of manual acq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_reg <= 1'b0;
      acq_shadow_reg <= 1'b0;
    end else if (wr && sel_bwc) begin
      auto_reg <= pwdata[PLLBW_AUTO_BIT];
      if (!auto_reg) begin
        acq_shadow_reg <= pwdata[PLLBW_ACQ_BIT];
      end
    end
  end

  // R7: loss detect only while vco drives output, cleared while crystal active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_loss_reg <= 1'b0;
    end else if (!base_clock_select_reg) begin
      crystal_loss_reg <= 1'b0;
    end else if (xl_s2_reg) begin
      crystal_loss_reg <= 1'b1;
    end else if (wr && sel_bwc) begin
      crystal_loss_reg <= pwdata[PLLBW_XLD_BIT];
    end else begin
      crystal_loss_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R11: R13: programming locked while pll on; R10: R12: reset six
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multiplier_field_reg <= PLLBW_MUL_RST;
      vco_range_field_reg <= PLLBW_VRS_RST;
    end else if (wr && sel_prg && !pll_on_control_reg) begin
      multiplier_field_reg <= pwdata[7:4];
      vco_range_field_reg <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic acq_vis;
  // R4: auto shows loop, manual shows forced value
  assign acq_vis = auto_reg ? trk_s2_reg : acq_shadow_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        PLLBW_CTL_OFF: prdata <= {24'h0, pll_interrupt_enable_reg, pll_interrupt_flag_reg,
                                  pll_on_control_reg, base_clock_select_reg, PLLBW_CTL_LOW};
        PLLBW_BWC_OFF: prdata <= {24'h0, auto_reg, lock_vis, acq_vis, crystal_loss_reg, 4'h0};
        PLLBW_PRG_OFF: prdata <= {24'h0, multiplier_field_reg, vco_range_field_reg};
        default: prdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R9: code zero behaves as one
  assign multiplier_n = (multiplier_field_reg == 4'h0) ? 4'h1 : multiplier_field_reg;
  assign vco_range = vco_range_field_reg;
  // R14: zero range disables loop; R20: stop disables
  assign pll_enable = pll_on_control_reg && (vco_range_field_reg != 4'h0) && !stop;
  assign force_tracking = acq_shadow_reg;
  assign auto_mode = auto_reg;
  // R24: R20: clock select, low in stop
  assign base_clock_output = !stop && (base_clock_select_reg ? vco_half : crystal_half);
  // R16: R20: request gated
  assign clockgen_interrupt = !stop && auto_reg && pll_interrupt_flag_reg
                              && pll_interrupt_enable_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  flag_set_a: assert property (lock_change |=> pll_interrupt_flag_reg) // R15
    else $error("lock change did not set flag");
  manual_flag_a: assert property (!auto_reg |=> !pll_interrupt_flag_reg) // R16
    else $error("flag set in manual mode");
  break_hold_a: assert property (pll_interrupt_flag_reg && auto_reg && break_active
      && !break_clear_enable |=> pll_interrupt_flag_reg) // R22
    else $error("flag cleared in protected break");
  read_clear_a: assert property (rd && sel_ctl && !break_active && !lock_change
      && auto_reg |=> !pll_interrupt_flag_reg) // R23
    else $error("control read did not clear flag");
  mul_lock_a: assert property (pll_on_control_reg |=> $stable(multiplier_field_reg)) // R11
    else $error("multiplier changed while pll on");
  vrs_lock_a: assert property (pll_on_control_reg |=> $stable(vco_range_field_reg)) // R13
    else $error("range changed while pll on");
  stop_bcs_a: assert property (stop |=> !base_clock_select_reg) // R21
    else $error("select not cleared in stop");
  zero_range_a: assert property (vco_range_field_reg == 4'h0 |=> !base_clock_select_reg) // R14
    else $error("select set with zero range");
  mul_zero_a: assert property (multiplier_n != 4'h0) // R9
    else $error("multiplier zero seen");
  stop_out_a: assert property (stop |-> !clockgen_interrupt && !base_clock_output) // R20
    else $error("outputs live in stop");
  xld_gate_a: assert property (!base_clock_select_reg |=> !crystal_loss_reg) // R7
    else $error("crystal loss without vco select");

  irq_c: cover property (lock_change ##1 clockgen_interrupt);
  vco_sel_c: cover property (!base_clock_select_reg ##1 base_clock_select_reg);
  stop_c: cover property (base_clock_select_reg ##1 stop);
  brk_c: cover property (break_active && rd && sel_ctl && pll_interrupt_flag_reg);
endmodule
`default_nettype wire

// *** tb/pllbw_far_model.sv ***
// far side model: loop status levels, half-rate vco and quarter-rate crystal clocks
`timescale 1ns/1ps
`default_nettype none
module pllbw_far_model (
  input wire logic pclk,
  input wire logic lock_req,
  input wire logic loss_req,
  output logic lock_in,
  output logic tracking_in,
  output logic crystal_loss_in,
  output logic vco_half,
  output logic crystal_half
);
  logic [1:0] div = 2'h0;
  always_ff @(posedge pclk) begin
    div <= div + 2'h1;
    lock_in <= lock_req;
    tracking_in <= lock_req;
    crystal_loss_in <= loss_req;
  end
  assign vco_half = div[0];
  assign crystal_half = div[1];
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the pll control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pllbw_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, oscillator_enable = 1'b1, wait_mode = 1'b0;
  logic break_active = 1'b0, break_clear_enable = 1'b0, lock_req = 1'b0, loss_req = 1'b0;
  logic lock_in, tracking_in, crystal_loss_in, vco_half, crystal_half, base_clock_output;
  logic clockgen_interrupt, pll_enable, force_tracking, auto_mode;
  logic [3:0] multiplier_n, vco_range;
  logic [7:0] v;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  pllbw_ctl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .oscillator_enable, .break_active, .break_clear_enable, .wait_mode, .lock_in,
    .tracking_in, .crystal_loss_in, .vco_half, .crystal_half, .base_clock_output,
    .clockgen_interrupt, .pll_enable, .multiplier_n, .vco_range, .force_tracking, .auto_mode);
  pllbw_far_model i_far (.pclk, .lock_req, .loss_req, .lock_in, .tracking_in, .crystal_loss_in,
    .vco_half, .crystal_half);
  initial begin
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  function automatic logic [7:0] ctl(input logic ie, fl, on, base_clock_select);
    return {ie, fl, on, base_clock_select, PLLBW_CTL_LOW};
  endfunction
  function automatic logic [3:0] mul_n(input logic [3:0] f);
    return (f == 4'h0) ? 4'h1 : f;
  endfunction
  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8658f855));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc(PLLBW_CTL_OFF, ctl(0, 0, 1, 0));
    rc(PLLBW_BWC_OFF, 8'h00);
    rc(PLLBW_PRG_OFF, {PLLBW_MUL_RST, PLLBW_VRS_RST});
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    wr(PLLBW_PRG_OFF, 8'h93);
    rc(PLLBW_PRG_OFF, 8'h66);
    wr(PLLBW_CTL_OFF, 8'h00);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h0f : (i == 1) ? 8'hf1 : 8'($urandom);
      wr(PLLBW_PRG_OFF, v);
      rc(PLLBW_PRG_OFF, v);
      chk({28'h0, multiplier_n}, {28'h0, mul_n(v[7:4])});
      chk({28'h0, vco_range}, {28'h0, v[3:0]});
    end
    @(negedge pclk);
    chk({31'h0, base_clock_output}, {31'h0, crystal_half});
    wr(PLLBW_PRG_OFF, 8'h30);
    wr(PLLBW_CTL_OFF, 8'h20);
    @(negedge pclk);
    chk({31'h0, pll_enable}, 32'h0);
    wr(PLLBW_CTL_OFF, 8'h30);
    rc(PLLBW_CTL_OFF, ctl(0, 0, 1, 0));
    wr(PLLBW_CTL_OFF, 8'h00);
    wr(PLLBW_PRG_OFF, 8'h26);
    wr(PLLBW_CTL_OFF, 8'h20);
    wr(PLLBW_CTL_OFF, 8'h30);
    wr(PLLBW_CTL_OFF, 8'h10);
    rc(PLLBW_CTL_OFF, ctl(0, 0, 1, 1));
    repeat (3) begin
      @(negedge pclk);
      chk({30'h0, base_clock_output, pll_enable}, {30'h0, vco_half, 1'b1});
    end
    @(posedge pclk);
    loss_req <= 1'b1;
    wr(PLLBW_BWC_OFF, 8'h10);
    repeat (4 * 2) @(posedge pclk);
    rc(PLLBW_BWC_OFF, 8'h10);
    loss_req <= 1'b0;
    repeat (4) @(posedge pclk);
    wr(PLLBW_BWC_OFF, 8'h10);
    repeat (4 * 2) @(posedge pclk);
    rc(PLLBW_BWC_OFF, 8'h00);
    $display("test program done");
    oscillator_enable <= 1'b0;
    repeat (2) begin
      @(negedge pclk);
      chk({29'h0, base_clock_output, clockgen_interrupt, pll_enable}, 32'h0);
    end
    @(posedge pclk);
    oscillator_enable <= 1'b1;
    rc(PLLBW_CTL_OFF, ctl(0, 0, 1, 0));
    rc(PLLBW_BWC_OFF, 8'h00);
    $display("test stop done");
    wait_mode <= 1'b1;
    wr(PLLBW_BWC_OFF, 8'h20);
    lock_req <= 1'b1;
    @(negedge pclk);
    chk({31'h0, force_tracking}, 32'h1);
    wr(PLLBW_CTL_OFF, 8'ha0);
    rc(PLLBW_BWC_OFF, 8'h20);
    rc(PLLBW_CTL_OFF, ctl(0, 0, 1, 0));
    wr(PLLBW_BWC_OFF, 8'ha0);
    wr(PLLBW_BWC_OFF, 8'h80);
    rc(PLLBW_BWC_OFF, 8'he0);
    chk({31'h0, auto_mode}, 32'h1);
    wr(PLLBW_CTL_OFF, 8'ha0);
    lock_req <= 1'b0;
    repeat (6) @(negedge pclk);
    chk({31'h0, clockgen_interrupt}, 32'h1);
    rc(PLLBW_BWC_OFF, 8'h80);
    @(posedge pclk);
    break_active <= 1'b1;
    rc(PLLBW_CTL_OFF, ctl(1, 1, 1, 0));
    rc(PLLBW_CTL_OFF, ctl(1, 1, 1, 0));
    break_clear_enable <= 1'b1;
    rc(PLLBW_CTL_OFF, ctl(1, 1, 1, 0));
    break_active <= 1'b0;
    break_clear_enable <= 1'b0;
    rc(PLLBW_CTL_OFF, ctl(1, 0, 1, 0));
    lock_req <= 1'b1;
    repeat (6) @(posedge pclk);
    rc(PLLBW_CTL_OFF, ctl(1, 1, 1, 0));
    rc(PLLBW_CTL_OFF, ctl(1, 0, 1, 0));
    wr(PLLBW_CTL_OFF, 8'h20);
    lock_req <= 1'b0;
    repeat (6) @(negedge pclk);
    chk({31'h0, clockgen_interrupt}, 32'h0);
    rc(PLLBW_CTL_OFF, ctl(0, 1, 1, 0));
    wr(PLLBW_BWC_OFF, 8'h00);
    rc(PLLBW_BWC_OFF, 8'h20);
    rc(PLLBW_PRG_OFF, 8'h26);
    $display("test auto done");
    test_done();
  end
endmodule
`default_nettype wire
